// *** verilog/pidacc_defines.vh ***
`ifndef PIDACC_DEFINES_VH
`define PIDACC_DEFINES_VH

`define PA_ADDR_W 8
`define PA_OFF_CTRL 8'h00
`define PA_OFF_SETPT 8'h04
`define PA_OFF_INPUT 8'h08
`define PA_OFF_COEFA 8'h0c
`define PA_OFF_COEFB 8'h10
`define PA_OFF_COEFC 8'h14
`define PA_OFF_OUTU 8'h18
`define PA_OFF_OUTM 8'h1c
`define PA_OFF_OUTL 8'h20
`define PA_OFF_ACCH 8'h24
`define PA_OFF_STAT 8'h28
`define PA_OFF_MASK 8'h2c
`define PA_OFF_CLRACC 8'h30

`define PA_MODE_UMAD 3'h0
`define PA_MODE_UMAC 3'h1
`define PA_MODE_SMAD 3'h2
`define PA_MODE_SMAC 3'h3
`define PA_MODE_PID 3'h5

`define PA_CTRL_EN 3
`define PA_CTRL_BUSY 4

`define PA_ST_DONE 0
`define PA_ST_ERR 1

`define PA_ACC_W 35
`define PA_OPD_W 16
`define PA_PID_STEPS 3'h3

`endif

// *** verilog/pidacc_history.v ***
`timescale 1ns/1ps
// Holds the error history of the controller: index 0 is e[n-1], 1 is e[n-2].
module pidacc_history (
    input wire clk,
    input wire arst_n,
    input wire wr_en,
    input wire clr,
    input wire [15:0] wr_data,
    input wire rd_addr,
    output reg [15:0] rd_data_ff
);
    reg [15:0] mem_ff [0:1];

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mem_ff[0] <= 16'h0000;
            mem_ff[1] <= 16'h0000;
            rd_data_ff <= 16'h0000;
        end
        else
        begin
            if (clr)
            begin
                mem_ff[0] <= 16'h0000;
                mem_ff[1] <= 16'h0000;
            end
            else if (wr_en)
            begin
                mem_ff[1] <= mem_ff[0];
                mem_ff[0] <= wr_data;
            end
            rd_data_ff <= mem_ff[rd_addr];
        end
    end
endmodule

// *** verilog/pidacc_mac.v ***
`timescale 1ns/1ps
`include "pidacc_defines.vh"
// One multiply-add step on the shared accumulator.
module pidacc_mac (
    input wire [15:0] opa,
    input wire [15:0] opb,
    input wire is_signed,
    input wire [34:0] acc_in,
    output wire [34:0] acc_out,
    output wire ovf
);
    wire [16:0] ea;
    wire [16:0] eb;
    wire signed [33:0] prod;
    wire signed [35:0] sum;

    assign ea = {is_signed & opa[15], opa};
    assign eb = {is_signed & opb[15], opb};
    assign prod = $signed(ea) * $signed(eb);
    assign sum = $signed({acc_in[34], acc_in}) +
                 $signed({{2{prod[33]}}, prod});
    assign acc_out = sum[34:0];
    assign ovf = sum[35] ^ sum[34];
endmodule

// *** verilog/pidacc_top.v ***
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
`include "pidacc_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// (RULE1) Products of a signed multiplier add into one 35-bit accumulator.
// (RULE2) Controller operands: three coefficients, error input, set point.
// (RULE3) A done flag and a separate error flag are raised to the interrupt.
// (RULE4) Unsigned and signed multiply-add, each with or without accumulation.
// (RULE5) The three-bit control mode field alone selects the mode.
// (RULE6) Mode code 101 runs the controller calculation.
// (RULE7) Controller sums error, error history and the second difference.
// (RULE8) Coefficients go through the same multiplier and accumulator.
// (RULE9) Software loops: writes each new input, reads the result back.
// (RULE10) Result bits 23:16, 15:8 and 7:0 appear in three byte registers.
// (RULE11) The result byte registers are writable and reset to zero.
// (RULE12) Codes 4, 6 and 7 are reserved; a start with them raises the error.
module pidacc_top (
    input wire CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    output reg IRQ
);
    localparam S_IDLE = 2'h0;
    localparam S_LOAD = 2'h1;
    localparam S_RUN = 2'h2;
    localparam S_DONE = 2'h3;

    reg [2:0] mode_ff;
    reg en_ff;
    reg [15:0] setpt_ff;
    reg [15:0] input_ff;
    reg [15:0] coef_a_ff;
    reg [15:0] coef_b_ff;
    reg [15:0] coef_c_ff;
    reg [7:0] out_u_ff;
    reg [7:0] out_m_ff;
    reg [7:0] out_l_ff;
    reg [34:0] acc_ff;
    reg [1:0] stat_ff;
    reg [1:0] mask_ff;
    reg [1:0] state_ff;
    reg [2:0] step_ff;
    reg [15:0] err_ff;
    reg [15:0] e1_ff;
    reg [34:0] nxt_acc;
    reg [1:0] nxt_state;
    reg [15:0] mac_a;
    reg [15:0] mac_b;
    reg mac_signed;
    reg [31:0] rdata;
    reg start;
    reg done_ev;
    reg err_ev;

    wire wr;
    wire rd;
    wire [15:0] hist_q;
    wire [34:0] mac_out;
    wire mac_ovf;
    wire [15:0] cur_err;
    wire hist_wr;
    wire hist_clr;

    function is_mode_valid;
        input [2:0] m;
        begin
            is_mode_valid = (m == `PA_MODE_UMAD) || (m == `PA_MODE_UMAC) ||
                            (m == `PA_MODE_SMAD) || (m == `PA_MODE_SMAC) ||
                            (m == `PA_MODE_PID);
        end
    endfunction

    assign wr = PSEL & PENABLE & PWRITE & PREADY;
    assign rd = PSEL & ~PENABLE & ~PWRITE;
    assign cur_err = setpt_ff - input_ff; // RULE2
    assign hist_wr = (state_ff == S_DONE) && (mode_ff == `PA_MODE_PID);
    assign hist_clr = wr && (PADDR == `PA_OFF_CLRACC);

    pidacc_history u_hist (
        .clk(CLK),
        .arst_n(ARST_N),
        .wr_en(hist_wr),
        .clr(hist_clr),
        .wr_data(err_ff),
        .rd_addr(1'b1),
        .rd_data_ff(hist_q)
    );

    pidacc_mac u_mac (
        .opa(mac_a),
        .opb(mac_b),
        .is_signed(mac_signed),
        .acc_in(acc_ff),
        .acc_out(mac_out),
        .ovf(mac_ovf)
    );

    //////////////////////////////////////////////////////////////////////////
    // The controller form is acc += a*e[n] + b*e[n-1] + c*e[n-2], with the
    // coefficients already folded by software into that discrete shape.
    always @*
    begin
        mac_a = input_ff;
        mac_b = coef_a_ff;
        mac_signed = (mode_ff == `PA_MODE_SMAD) ||
                     (mode_ff == `PA_MODE_SMAC) ||
                     (mode_ff == `PA_MODE_PID);
        if (mode_ff == `PA_MODE_PID)
        begin
            case (step_ff)
                3'h0:
                begin
                    mac_a = err_ff; // RULE7
                    mac_b = coef_a_ff;
                end
                3'h1:
                begin
                    mac_a = e1_ff; // RULE7
                    mac_b = coef_b_ff;
                end
                default:
                begin
                    mac_a = hist_q; // RULE7
                    mac_b = coef_c_ff;
                end
            endcase
        end
        else
        begin
            mac_a = input_ff; // RULE4
            mac_b = coef_a_ff;
        end
    end

    always @*
    begin
        start = wr && (PADDR == `PA_OFF_INPUT) && en_ff;
        done_ev = 1'b0;
        err_ev = 1'b0;
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        case (state_ff)
            S_IDLE:
            begin
                if (start)
                begin
                    if (is_mode_valid(mode_ff)) // RULE5
                        nxt_state = S_LOAD;
                    else
                        err_ev = 1'b1; // RULE12
                end
            end
            S_LOAD:
            begin
                nxt_state = S_RUN;
                if ((mode_ff == `PA_MODE_UMAD) || (mode_ff == `PA_MODE_SMAD))
                    nxt_acc = {`PA_ACC_W{1'b0}}; // RULE4
            end
            S_RUN:
            begin
                nxt_acc = mac_out; // RULE1 RULE8
                err_ev = mac_ovf; // RULE3
                if ((mode_ff != `PA_MODE_PID) ||
                    (step_ff == `PA_PID_STEPS - 3'h1)) // RULE6
                    nxt_state = S_DONE;
            end
            S_DONE:
            begin
                nxt_state = S_IDLE;
                done_ev = 1'b1; // RULE3
            end
            default:
                nxt_state = S_IDLE;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Datapath and sequencing.
    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state_ff <= S_IDLE;
            step_ff <= 3'h0;
            acc_ff <= {`PA_ACC_W{1'b0}};
            err_ff <= 16'h0000;
            e1_ff <= 16'h0000;
        end
        else
        begin
            state_ff <= nxt_state;
            if (hist_clr)
                acc_ff <= {`PA_ACC_W{1'b0}};
            else
                acc_ff <= nxt_acc;
            if (state_ff == S_LOAD)
                err_ff <= cur_err;
            if (state_ff == S_RUN)
                step_ff <= step_ff + 3'h1;
            else
                step_ff <= 3'h0;
            if (hist_clr)
                e1_ff <= 16'h0000;
            else if (hist_wr)
                e1_ff <= err_ff;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // APB register file.
    always @*
    begin
        case (PADDR)
            `PA_OFF_CTRL:
                rdata = {27'h0, state_ff != S_IDLE, en_ff, mode_ff};
            `PA_OFF_SETPT: rdata = {16'h0000, setpt_ff};
            `PA_OFF_INPUT: rdata = {16'h0000, input_ff};
            `PA_OFF_COEFA: rdata = {16'h0000, coef_a_ff};
            `PA_OFF_COEFB: rdata = {16'h0000, coef_b_ff};
            `PA_OFF_COEFC: rdata = {16'h0000, coef_c_ff};
            `PA_OFF_OUTU: rdata = {24'h000000, out_u_ff};
            `PA_OFF_OUTM: rdata = {24'h000000, out_m_ff};
            `PA_OFF_OUTL: rdata = {24'h000000, out_l_ff};
            `PA_OFF_ACCH: rdata = {21'h0, acc_ff[34:24]};
            `PA_OFF_STAT: rdata = {30'h00000000, stat_ff};
            `PA_OFF_MASK: rdata = {30'h00000000, mask_ff};
            default: rdata = 32'h00000000;
        endcase
    end

    always @(posedge CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            mode_ff <= `PA_MODE_UMAD;
            en_ff <= 1'b0;
            setpt_ff <= 16'h0000;
            input_ff <= 16'h0000;
            coef_a_ff <= 16'h0000;
            coef_b_ff <= 16'h0000;
            coef_c_ff <= 16'h0000;
            out_u_ff <= 8'h00; // RULE11
            out_m_ff <= 8'h00;
            out_l_ff <= 8'h00;
            stat_ff <= 2'h0;
            mask_ff <= 2'h0;
            PRDATA <= 32'h00000000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            PREADY <= PSEL & ~PENABLE;
            PSLVERR <= 1'b0;
            if (rd)
                PRDATA <= rdata;
            if (wr)
            begin
                case (PADDR)
                    `PA_OFF_CTRL:
                    begin
                        mode_ff <= PWDATA[2:0]; // RULE5
                        en_ff <= PWDATA[`PA_CTRL_EN];
                    end
                    `PA_OFF_SETPT: setpt_ff <= PWDATA[15:0];
                    `PA_OFF_INPUT: input_ff <= PWDATA[15:0]; // RULE9
                    `PA_OFF_COEFA: coef_a_ff <= PWDATA[15:0];
                    `PA_OFF_COEFB: coef_b_ff <= PWDATA[15:0];
                    `PA_OFF_COEFC: coef_c_ff <= PWDATA[15:0];
                    `PA_OFF_OUTU: out_u_ff <= PWDATA[7:0]; // RULE11
                    `PA_OFF_OUTM: out_m_ff <= PWDATA[7:0];
                    `PA_OFF_OUTL: out_l_ff <= PWDATA[7:0];
                    `PA_OFF_MASK: mask_ff <= PWDATA[1:0];
                    default: PSLVERR <= 1'b0;
                endcase
            end
            if (state_ff == S_DONE)
            begin
                out_u_ff <= acc_ff[23:16]; // RULE10
                out_m_ff <= acc_ff[15:8];
                out_l_ff <= acc_ff[7:0];
            end
            // A new event wins over a write-one clear in the same cycle.
            stat_ff[`PA_ST_DONE] <= done_ev | (stat_ff[`PA_ST_DONE] &
                ~(wr && (PADDR == `PA_OFF_STAT) && PWDATA[`PA_ST_DONE]));
            stat_ff[`PA_ST_ERR] <= err_ev | (stat_ff[`PA_ST_ERR] &
                ~(wr && (PADDR == `PA_OFF_STAT) && PWDATA[`PA_ST_ERR]));
            IRQ <= |(stat_ff & mask_ff); // RULE3
        end
    end
endmodule

// *** verification/pidacc_properties.sv ***
`timescale 1ns/1ps
`include "pidacc_defines.vh"
module pidacc_properties (
    input wire CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire PREADY,
    input wire PSLVERR,
    input wire IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire setup = PSEL && !PENABLE;
    wire kick = setup && PWRITE &&
        (PADDR == `PA_OFF_INPUT || PADDR == `PA_OFF_MASK);
    logic [3:0] since_ff;
    // Cycles since the setup phase of the last input or mask write, enabled or not, saturating at 15.
    always @(posedge CLK or negedge ARST_N)
        if (!ARST_N)
            since_ff <= 4'hf;
        else if (kick)
            since_ff <= 4'h0;
        else if (since_ff != 4'hf)
            since_ff <= since_ff + 4'h1;
    sequence rd_at(logic [7:0] a);
        setup && !PWRITE && PADDR == a;
    endsequence
    sequence mask_off;
        setup && PWRITE && PADDR == `PA_OFF_MASK && PWDATA == 32'h0;
    endsequence
    ready_next_a: assert property (setup |=> PREADY && PENABLE)
        else $error("access phase not answered");
    ready_only_a: assert property (PREADY |-> $past(setup))
        else $error("ready without setup");
    no_slverr_a: assert property (!PSLVERR)
        else $error("slave error raised");
    res_byte_a: assert property (rd_at(`PA_OFF_OUTU) or
        rd_at(`PA_OFF_OUTM) or rd_at(`PA_OFF_OUTL) |=> PRDATA[31:8] == 24'h0)
        else $error("result byte too wide");
    acc_top_a: assert property (rd_at(`PA_OFF_ACCH)
        |=> PRDATA[31:11] == 21'h0) else $error("accumulator too wide");
    ctrl_read_a: assert property (rd_at(`PA_OFF_CTRL)
        |=> PRDATA[31:5] == 27'h0) else $error("control too wide");
    stat_read_a: assert property (rd_at(`PA_OFF_STAT)
        |=> PRDATA[31:2] == 30'h0) else $error("status too wide");
    unmapped_a: assert property (setup && !PWRITE && PADDR > 8'h30
        |=> PRDATA == 32'h0) else $error("unmapped read not zero");
    irq_cause_a: assert property ($rose(IRQ) |-> since_ff < 4'hc)
        else $error("interrupt without cause");
    irq_masked_a: assert property (mask_off |-> ##[1:3] !IRQ)
        else $error("masked interrupt stays high");
endmodule
bind pidacc_top pidacc_properties u_props (.CLK(CLK), .ARST_N(ARST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ));

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`include "pidacc_defines.vh"
module testbench;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] rd;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire irq;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] outs [3] = '{`PA_OFF_OUTU, `PA_OFF_OUTM, `PA_OFF_OUTL};
    always #12.5 clk = ~clk;
    pidacc_top uut (.CLK(clk), .ARST_N(arst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (i >= 20)
        begin
            n_errors++;
            $display("unexpected at %0t: no ready", $time);
            report_and_stop();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic res(input logic [23:0] e);
        for (int k = 0; k < 3; k++)
            rchk(outs[k], {24'h0, e[23-8*k -: 8]});
    endtask
    // Clears status, starts a calculation and waits for done or error.
    task automatic calc(input logic [31:0] v);
        int i;
        bus(1'b1, `PA_OFF_STAT, 32'h3);
        bus(1'b1, `PA_OFF_INPUT, v);
        i = 0;
        do
        begin
            bus(1'b0, `PA_OFF_STAT, 32'h0);
            i++;
        end while (rd[1:0] === 2'b00 && i < 20);
        if (i >= 20)
        begin
            n_errors++;
            $display("unexpected at %0t: no completion", $time);
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        res(24'h0);
        rchk(`PA_OFF_STAT, 32'h0);
        rchk(8'h34, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, outs[k], 32'ha5 + k);
            rchk(outs[k], 32'ha5 + k);
        end
        bus(1'b1, `PA_OFF_COEFA, 32'hffff);
        bus(1'b1, `PA_OFF_INPUT, 32'h5);
        repeat (8) @(posedge clk);
        rchk(`PA_OFF_STAT, 32'h0);
        res(24'ha5a6a7);
        bus(1'b1, `PA_OFF_MASK, 32'h1);
        bus(1'b1, `PA_OFF_CTRL, 32'h8);
        calc(32'hffff);
        res(24'hfe0001);
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `PA_OFF_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, `PA_OFF_CTRL, 32'h9);
        calc(32'hffff);
        res(24'hfc0002);
        rchk(`PA_OFF_ACCH, 32'h1ff);
        bus(1'b1, `PA_OFF_CTRL, 32'ha);
        calc(32'h2);
        res(24'hfffffe);
        rchk(`PA_OFF_ACCH, 32'h7ff);
        bus(1'b1, `PA_OFF_CTRL, 32'hb);
        calc(32'h2);
        res(24'hfffffc);
        for (int k = 0; k < 3; k++)
        begin
            bus(1'b1, `PA_OFF_CTRL, (k == 0) ? 32'hc : 32'hd + k);
            calc(32'h1);
            chk(rd, 32'h2);
        end
        res(24'hfffffc);
        // Four unsigned accumulations fit; the fifth overflows 35 bits.
        bus(1'b1, `PA_OFF_CTRL, 32'h9);
        for (int k = 0; k < 5; k++)
            calc(32'hffff);
        chk({31'h0, rd[1]}, 32'h1);
        bus(1'b1, `PA_OFF_CLRACC, 32'h1);
        bus(1'b1, `PA_OFF_CTRL, 32'hd);
        bus(1'b1, `PA_OFF_SETPT, 32'ha);
        bus(1'b1, `PA_OFF_COEFA, 32'h1);
        bus(1'b1, `PA_OFF_COEFB, 32'h2);
        bus(1'b1, `PA_OFF_COEFC, 32'h3);
        calc(32'h4);
        res(24'h6);
        calc(32'h7);
        res(24'h15);
        calc(32'ha);
        res(24'h2d);
        calc(32'hc);
        res(24'h34);
        rchk(`PA_OFF_STAT, 32'h1);
        rchk(`PA_OFF_CTRL, 32'hd);
        report_and_stop();
    end
endmodule
